// ===== include/pcsd_defs.vh
// Offsets, field positions and reset values of the clock select/divide slice.
// Included by the divider and top design files; definitions only.
`ifndef PCSD_DEFS_VH
`define PCSD_DEFS_VH

// Register byte offsets
`define PCSD_ADDR_W 12
`define PCSD_OFF_SERIAL_BUS3 12'h0170
`define PCSD_OFF_PULSE_WIDTH 12'h0174
`define PCSD_OFF_PERIPH_SER0 12'h0178
`define PCSD_OFF_PERIPH_SER1 12'h017c
`define PCSD_OFF_PERIPH_SER2 12'h0180
`define PCSD_OFF_TEMP_CONV 12'h0184
`define PCSD_OFF_STATUS 12'h0200

// Write mask in the upper half, value in the lower half
`define PCSD_MASK_HI 31
`define PCSD_MASK_LO 16
`define PCSD_MASK_RD 16'h0000

// Field positions
`define PCSD_SEL_HI 15
`define PCSD_SEL_LO 14
`define PCSD_DIV7_HI 6
`define PCSD_DIV11_HI 10
`define PCSD_DIV_LO 0

// Implemented lower-half bits; the rest are reserved, read zero
`define PCSD_IMPL_SELDIV 16'hc07f
`define PCSD_IMPL_DIV11 16'h07ff

// Reset values of the lower halves
`define PCSD_RST_SERIAL_BUS3 16'h0005
`define PCSD_RST_PULSE_WIDTH 16'h000b
`define PCSD_RST_PERIPH_SER0 16'h000b
`define PCSD_RST_PERIPH_SER1 16'h000b
`define PCSD_RST_PERIPH_SER2 16'h000b
`define PCSD_RST_TEMP_CONV 16'h0001

// Source select codes
`define PCSD_SEL_FIRST_PLL 2'b00
`define PCSD_SEL_SECOND_PLL 2'b01
`define PCSD_SEL_CRYSTAL 2'b10
`define PCSD_SEL_NONE 2'b11

`endif

// ===== rtl/pcsd_mask_reg.v
// Lower half of one masked control word.
// Assumes a one-cycle write strobe from the register decode.
`timescale 1ns/10ps
module pcsd_mask_reg #(
    parameter [15:0] IMPL = 16'hffff,
    parameter [15:0] RST = 16'h0000
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Write port
    input wire we_i,
    input wire [15:0] data_i,
    input wire [15:0] mask_i,
    // Stored value
    output reg [15:0] q_o
);
    wire [15:0] upd;

    // Only implemented bits with their mask bit set may change
    assign upd = mask_i & IMPL;

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
            q_o <= RST;
        else if (we_i)
            q_o <= (q_o & ~upd) | (data_i & upd);
    end
endmodule

// ===== rtl/pcsd_clk_div.v
// One kernel clock: source pick and divide by value plus one.
// Sources arrive as one-cycle enable pulses on clk_i.
`timescale 1ns/10ps
`include "pcsd_defs.vh"
module pcsd_clk_div #(
    parameter DW = 7
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Source enables: first PLL, second PLL, crystal
    input wire [2:0] src_tick_i,
    // Requested setting
    input wire [1:0] sel_i,
    input wire [DW-1:0] div_i,
    // Divided output and update-pending flag
    output reg tick_o,
    output reg clk_o,
    output wire pending_o
);
    reg [1:0] sel_q;
    reg [DW-1:0] div_q;
    reg [DW-1:0] cnt_q;
    reg src;
    wire wrap;
    wire [DW-1:0] cnt_d;
    wire [DW-1:0] hi_len;

    always @*
    begin
        case (sel_q)
            `PCSD_SEL_FIRST_PLL: src = src_tick_i[0];
            `PCSD_SEL_SECOND_PLL: src = src_tick_i[1];
            `PCSD_SEL_CRYSTAL: src = src_tick_i[2];
            default: src = 1'b0;
        endcase
    end

    assign wrap = (cnt_q == div_q);
    assign cnt_d = wrap ? {DW{1'b0}} : cnt_q + {{(DW-1){1'b0}}, 1'b1};
    assign hi_len = (div_q >> 1) + {{(DW-1){1'b0}}, 1'b1};
    assign pending_o = (sel_i != sel_q) || (div_i != div_q);

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            sel_q <= 2'b00;
            div_q <= {DW{1'b0}};
            cnt_q <= {DW{1'b0}};
            tick_o <= 1'b0;
            clk_o <= 1'b0;
        end
        else
        begin
            tick_o <= src & wrap;
            if (src)
            begin
                cnt_q <= cnt_d;
                clk_o <= (cnt_d < hi_len);
            end
            // New settings at a period boundary, or at once while stopped, so no runt pulse
            if ((src && wrap) || sel_q == `PCSD_SEL_NONE)
            begin
                sel_q <= sel_i;
                div_q <= div_i;
                cnt_q <= {DW{1'b0}};
            end
        end
    end
endmodule

// ===== rtl/pcsd_top.v
// Peripheral kernel clock select and divide: six masked control words
// and six dividers. Sources are enable pulses made on clk_i by the
// surrounding clock unit; outputs are divided enables and levels.
//
// Notes on behaviour
// - A write changes a low-half bit only where its upper mask bit is one.
// - Unmasked low bits keep their value; the mask half reads 0x0000.
// - Serial bus 3 word at 0x0170: select 15:14, divisor 6:0 reset 0x05.
// - Pulse-width word at 0x0174: same select, seven-bit divisor reset 0x0b.
// - Peripheral serial 0 word at 0x0178: select 15:14, divisor reset 0x0b.
// - Peripheral serial 1 word at 0x017c: select, divisor reset 0x0b.
// - Peripheral serial 2 word at 0x0180: select 15:14, divisor reset 0x0b.
// - Temperature converter at 0x0184: crystal divided by bits 10:0 plus one.
`timescale 1ns/10ps
`include "pcsd_defs.vh"
module pcsd_top (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Register port
    input wire [11:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    // Source enables
    input wire first_pll_source_i,
    input wire second_pll_source_i,
    input wire crystal_oscillator_input_i,
    // Serial bus 3 kernel clock
    output wire serial_bus3_tick_o,
    output wire serial_bus3_clk_o,
    // Pulse-width kernel clock
    output wire pulse_width_tick_o,
    output wire pulse_width_clk_o,
    // Peripheral serial 0 kernel clock
    output wire periph_serial0_tick_o,
    output wire periph_serial0_clk_o,
    // Peripheral serial 1 kernel clock
    output wire periph_serial1_tick_o,
    output wire periph_serial1_clk_o,
    // Peripheral serial 2 kernel clock
    output wire periph_serial2_tick_o,
    output wire periph_serial2_clk_o,
    // Temperature converter kernel clock
    output wire temp_converter_tick_o,
    output wire temp_converter_clk_o
);
    // Bus fields
    wire [15:0] wr_mask;
    wire [15:0] wr_val;
    wire [2:0] src_ticks;

    // Write strobes per word
    wire we_sb3;
    wire we_pwm;
    wire we_ps0;
    wire we_ps1;
    wire we_ps2;
    wire we_tc;

    // Stored lower halves
    wire [15:0] sb3_q;
    wire [15:0] pwm_q;
    wire [15:0] ps0_q;
    wire [15:0] ps1_q;
    wire [15:0] ps2_q;
    wire [15:0] tc_q;

    // Pending updates, one per divider
    wire [5:0] pending;

    // Read path
    reg [31:0] rdata_d;

    assign wr_mask = wdata_i[`PCSD_MASK_HI:`PCSD_MASK_LO];
    assign wr_val = wdata_i[15:0];
    assign src_ticks = {crystal_oscillator_input_i,
                        second_pll_source_i,
                        first_pll_source_i};

    // Address decode
    assign we_sb3 = wr_i && (addr_i == `PCSD_OFF_SERIAL_BUS3);
    assign we_pwm = wr_i && (addr_i == `PCSD_OFF_PULSE_WIDTH);
    assign we_ps0 = wr_i && (addr_i == `PCSD_OFF_PERIPH_SER0);
    assign we_ps1 = wr_i && (addr_i == `PCSD_OFF_PERIPH_SER1);
    assign we_ps2 = wr_i && (addr_i == `PCSD_OFF_PERIPH_SER2);
    assign we_tc = wr_i && (addr_i == `PCSD_OFF_TEMP_CONV);

    // Control words; reserved bits are never stored
    pcsd_mask_reg #(
        .IMPL(`PCSD_IMPL_SELDIV),
        .RST(`PCSD_RST_SERIAL_BUS3)
    ) u_reg_sb3 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(we_sb3),
        .data_i(wr_val),
        .mask_i(wr_mask),
        .q_o(sb3_q)
    );

    pcsd_mask_reg #(
        .IMPL(`PCSD_IMPL_SELDIV),
        .RST(`PCSD_RST_PULSE_WIDTH)
    ) u_reg_pwm (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(we_pwm),
        .data_i(wr_val),
        .mask_i(wr_mask),
        .q_o(pwm_q)
    );

    pcsd_mask_reg #(
        .IMPL(`PCSD_IMPL_SELDIV),
        .RST(`PCSD_RST_PERIPH_SER0)
    ) u_reg_ps0 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(we_ps0),
        .data_i(wr_val),
        .mask_i(wr_mask),
        .q_o(ps0_q)
    );

    pcsd_mask_reg #(
        .IMPL(`PCSD_IMPL_SELDIV),
        .RST(`PCSD_RST_PERIPH_SER1)
    ) u_reg_ps1 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(we_ps1),
        .data_i(wr_val),
        .mask_i(wr_mask),
        .q_o(ps1_q)
    );

    pcsd_mask_reg #(
        .IMPL(`PCSD_IMPL_SELDIV),
        .RST(`PCSD_RST_PERIPH_SER2)
    ) u_reg_ps2 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(we_ps2),
        .data_i(wr_val),
        .mask_i(wr_mask),
        .q_o(ps2_q)
    );

    // Converter word has no select field: bits 15:11 stay zero
    pcsd_mask_reg #(
        .IMPL(`PCSD_IMPL_DIV11),
        .RST(`PCSD_RST_TEMP_CONV)
    ) u_reg_tc (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(we_tc),
        .data_i(wr_val),
        .mask_i(wr_mask),
        .q_o(tc_q)
    );

    // Dividers; select code 11 leaves the output still
    pcsd_clk_div #(
        .DW(7)
    ) u_div_sb3 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .src_tick_i(src_ticks),
        .sel_i(sb3_q[`PCSD_SEL_HI:`PCSD_SEL_LO]),
        .div_i(sb3_q[`PCSD_DIV7_HI:`PCSD_DIV_LO]),
        .tick_o(serial_bus3_tick_o),
        .clk_o(serial_bus3_clk_o),
        .pending_o(pending[0])
    );

    pcsd_clk_div #(
        .DW(7)
    ) u_div_pwm (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .src_tick_i(src_ticks),
        .sel_i(pwm_q[`PCSD_SEL_HI:`PCSD_SEL_LO]),
        .div_i(pwm_q[`PCSD_DIV7_HI:`PCSD_DIV_LO]),
        .tick_o(pulse_width_tick_o),
        .clk_o(pulse_width_clk_o),
        .pending_o(pending[1])
    );

    pcsd_clk_div #(
        .DW(7)
    ) u_div_ps0 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .src_tick_i(src_ticks),
        .sel_i(ps0_q[`PCSD_SEL_HI:`PCSD_SEL_LO]),
        .div_i(ps0_q[`PCSD_DIV7_HI:`PCSD_DIV_LO]),
        .tick_o(periph_serial0_tick_o),
        .clk_o(periph_serial0_clk_o),
        .pending_o(pending[2])
    );

    pcsd_clk_div #(
        .DW(7)
    ) u_div_ps1 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .src_tick_i(src_ticks),
        .sel_i(ps1_q[`PCSD_SEL_HI:`PCSD_SEL_LO]),
        .div_i(ps1_q[`PCSD_DIV7_HI:`PCSD_DIV_LO]),
        .tick_o(periph_serial1_tick_o),
        .clk_o(periph_serial1_clk_o),
        .pending_o(pending[3])
    );

    pcsd_clk_div #(
        .DW(7)
    ) u_div_ps2 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .src_tick_i(src_ticks),
        .sel_i(ps2_q[`PCSD_SEL_HI:`PCSD_SEL_LO]),
        .div_i(ps2_q[`PCSD_DIV7_HI:`PCSD_DIV_LO]),
        .tick_o(periph_serial2_tick_o),
        .clk_o(periph_serial2_clk_o),
        .pending_o(pending[4])
    );

    // Converter runs from the crystal once its first setting applies; reset selects the first PLL
    pcsd_clk_div #(
        .DW(11)
    ) u_div_tc (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .src_tick_i(src_ticks),
        .sel_i(`PCSD_SEL_CRYSTAL),
        .div_i(tc_q[`PCSD_DIV11_HI:`PCSD_DIV_LO]),
        .tick_o(temp_converter_tick_o),
        .clk_o(temp_converter_clk_o),
        .pending_o(pending[5])
    );

    // Read mux; the mask half always reads zero
    always @*
    begin
        case (addr_i)
            `PCSD_OFF_SERIAL_BUS3:
                rdata_d = {`PCSD_MASK_RD, sb3_q};
            `PCSD_OFF_PULSE_WIDTH:
                rdata_d = {`PCSD_MASK_RD, pwm_q};
            `PCSD_OFF_PERIPH_SER0:
                rdata_d = {`PCSD_MASK_RD, ps0_q};
            `PCSD_OFF_PERIPH_SER1:
                rdata_d = {`PCSD_MASK_RD, ps1_q};
            `PCSD_OFF_PERIPH_SER2:
                rdata_d = {`PCSD_MASK_RD, ps2_q};
            `PCSD_OFF_TEMP_CONV:
                rdata_d = {`PCSD_MASK_RD, tc_q};
            `PCSD_OFF_STATUS:
                rdata_d = {26'h000_0000, pending};
            default:
                rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
            rdata_o <= 32'h0000_0000;
        else if (rd_i)
            rdata_o <= rdata_d;
        else
            rdata_o <= 32'h0000_0000;
    end
endmodule

// ===== dv/pcsd_top_chk.sv
// Assertions on the ports of the clock select/divide slice.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module pcsd_top_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // Sources and divided outputs
    input wire logic first_pll_source_i,
    input wire logic second_pll_source_i,
    input wire logic crystal_oscillator_input_i,
    input wire logic serial_bus3_tick_o,
    input wire logic temp_converter_tick_o,
    input wire logic temp_converter_clk_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire any_src = first_pll_source_i | second_pll_source_i |
        crystal_oscillator_input_i;

    rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data not zero outside a read");
    mask_half_a: assert property (rd_i |=> rdata_o[31:16] == 16'h0000)
        else $error("mask half reads nonzero");
    sel_reserved_a: assert property (
        rd_i && addr_i >= 12'h170 && addr_i <= 12'h180
        |=> rdata_o[13:7] == 7'h00) else $error("reserved bits set");
    conv_reserved_a: assert property (
        rd_i && addr_i == 12'h184 |=> rdata_o[15:11] == 5'h00)
        else $error("converter reserved bits set");
    write_back_a: assert property (
        (wr_i && addr_i == 12'h170 && wdata_i[31:16] == 16'hffff)
        ##1 (rd_i && addr_i == 12'h170)
        |=> rdata_o[15:0] == ($past(wdata_i[15:0], 2) & 16'hc07f))
        else $error("written word not read back");
    unmapped_zero_a: assert property (
        rd_i && addr_i == 12'h1fc |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    bus3_tick_src_a: assert property (
        serial_bus3_tick_o |-> $past(any_src))
        else $error("tick without a source pulse");
    conv_clk_src_a: assert property (
        $changed(temp_converter_clk_o) && $past(rst_n_i) |-> $past(any_src))
        else $error("converter clock moved without a source pulse");

    cover property (rd_i ##1 rdata_o != 32'h0000_0000);
    cover property (serial_bus3_tick_o);
    cover property (temp_converter_tick_o);
endmodule
bind pcsd_top pcsd_top_chk u_chk (
    .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .first_pll_source_i, .second_pll_source_i, .crystal_oscillator_input_i,
    .serial_bus3_tick_o, .temp_converter_tick_o, .temp_converter_clk_o
);

// ===== dv/tb_top.sv
// Self-checking bench for the clock select/divide slice.
// Drives the register port and the three source enables directly.
`timescale 1ns/10ps
module tb_top;
    reg clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg [11:0] addr_i = 12'h000;
    reg [31:0] wdata_i = 32'h0000_0000;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg [2:0] src = 3'b000;
    reg full = 1'b0;
    reg clr = 1'b0;
    reg [31:0] seed = 32'h0000_8634;
    reg [31:0] d;
    reg [15:0] model [0:5];
    reg [15:0] cfg [0:5];
    wire [31:0] rdata_o;
    wire [5:0] tk;
    wire [5:0] ck;
    integer cnt [0:5];
    integer hi [0:5];
    integer fails = 0;
    integer num_checks = 0;
    integer cyc = 0;
    integer j, k;

    pcsd_top u_pcsd_top (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .first_pll_source_i(src[0]), .second_pll_source_i(src[1]),
        .crystal_oscillator_input_i(src[2]),
        .serial_bus3_tick_o(tk[0]), .serial_bus3_clk_o(ck[0]),
        .pulse_width_tick_o(tk[1]), .pulse_width_clk_o(ck[1]),
        .periph_serial0_tick_o(tk[2]), .periph_serial0_clk_o(ck[2]),
        .periph_serial1_tick_o(tk[3]), .periph_serial1_clk_o(ck[3]),
        .periph_serial2_tick_o(tk[4]), .periph_serial2_clk_o(ck[4]),
        .temp_converter_tick_o(tk[5]), .temp_converter_clk_o(ck[5])
    );

    always #5 clk_i = ~clk_i;

    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function [15:0] impl(input integer n);
        impl = (n == 5) ? 16'h07ff : 16'hc07f;
    endfunction

    // Select 11 stops a channel; the converter ignores select bits
    function integer exp_ticks(input [15:0] c, input integer n);
        exp_ticks = (n != 5 && c[15:14] == 2'b11) ? 0 :
            60 / ((n == 5 ? c[10:0] : {4'h0, c[6:0]}) + 1);
    endfunction

    // Divided level is high for ceil((div+1)/2) of every div+1 pulses
    function integer exp_high(input [15:0] c, input integer n);
        integer dv;
    begin
        dv = (n == 5) ? c[10:0] : c[6:0];
        exp_high = (60 / (dv + 1)) * ((dv + 2) / 2);
    end
    endfunction

    // Random source pulses, or all sources every cycle for rate checks
    always @(posedge clk_i)
    begin
        seed <= lfsr(seed);
        src <= full ? 3'b111 : seed[2:0];
        cyc <= cyc + 1;
        for (k = 0; k < 6; k = k + 1)
        begin
            cnt[k] <= clr ? 0 : cnt[k] + tk[k];
            hi[k] <= clr ? 0 : hi[k] + ck[k];
        end
        if (cyc == 10000)
        begin
            fails = fails + 1;
            tally_and_finish;
        end
    end

    task check(input [31:0] seen, input [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    end
    endtask

    task wr(input [11:0] a, input [31:0] v);
    begin
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    end
    endtask

    // Data are looked at just after the edge that follows the strobe
    task rd(input [11:0] a, input [31:0] exp);
    begin
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    end
    endtask

    task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    initial
    begin
        model[0] = 16'h0005;
        for (j = 1; j < 5; j = j + 1)
            model[j] = 16'h000b;
        model[5] = 16'h0001;
        cfg[0] = 16'h0002;
        cfg[1] = 16'hc004;
        cfg[2] = 16'h4004;
        cfg[3] = 16'h0005;
        cfg[4] = 16'h8000;
        cfg[5] = 16'h0003;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (j = 0; j < 6; j = j + 1)
            rd(12'h170 + 4 * j, {16'h0000, model[j]});
        // Zero mask must leave the word alone; unmapped place stays zero
        wr(12'h178, 32'h0000_ffff);
        rd(12'h178, {16'h0000, model[2]});
        wr(12'h1fc, 32'hffff_ffff);
        rd(12'h1fc, 32'h0000_0000);
        repeat (30)
        begin
            j = seed[15:0] % 6;
            d = seed;
            wr(12'h170 + 4 * j, d);
            model[j] = ((model[j] & ~d[31:16]) | (d[15:0] & d[31:16]))
                & impl(j);
            rd(12'h170 + 4 * j, {16'h0000, model[j]});
        end
        for (j = 0; j < 6; j = j + 1)
        begin
            wr(12'h170 + 4 * j, {16'hffff, cfg[j]});
            rd(12'h170 + 4 * j, {16'h0000, cfg[j] & impl(j)});
        end
        // Longest old divisor must wrap before new settings apply
        full <= 1'b1;
        repeat (2200) @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (60) @(posedge clk_i);
        #1;
        for (j = 0; j < 6; j = j + 1)
            check(cnt[j], exp_ticks(cfg[j], j));
        // A stopped channel holds whatever level it had; not compared
        for (j = 0; j < 6; j = j + 1)
            if (j != 1)
                check(hi[j], exp_high(cfg[j], j));
        // Every divider has taken its settings by now
        rd(12'h200, 32'h0000_0000);
        tally_and_finish;
    end
endmodule
